// ===== hdl/fault_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Input overvoltage: outputs off, standby, flag, interrupt.
// RULE2: Overvoltage cleared: leave standby, restart start-up.
// RULE3: Supply undervoltage: outputs off, standby, flag, interrupt.
// RULE4: Supply recovered: return to operation automatically.
// RULE5: Input overcurrent: off, flag, interrupt, retry 100ms.
// RULE6: Cycle current limiting never raises a fault.
// RULE7: Charge pump low: off, flag, interrupt, retry.
// RULE8: Flying capacitor fault: both flags, recovery, retry.
// RULE9: Default-load check failure flags only, keeps running.
// RULE10: Low overvoltage: flag, pause switching, no recovery.
// RULE11: Low overvoltage checked in soft-start/normal only.
// RULE12: High overvoltage: flag, interrupt, recovery, retry.
// RULE13: High overvoltage checked in soft-start/normal only.
// RULE14: Feedback undervoltage 110ms: overcurrent flag, recovery.
// RULE15: Overcurrent monitoring active from boost start.
// RULE16: Bad config resistor: flag, fall back 4ch/200mA.
// RULE17: Channel configuration latched after initialisation.
// RULE18: Host reads status flags after interrupt.
// RULE19: Flags sticky until host clears; recurrence resets.
module fault_supervisor
    import fault_sup_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = RESTART_CYC,
    parameter int unsigned OCP_CYCLES = OCP_WAIT_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire fault_sup_pkg::comp_t COMP_IN,
    input wire logic BOOST_CYCLE_LIMIT,
    input wire logic INIT_DONE,
    input wire logic CAP_FAULT,
    input wire logic LOAD_CHECK_FAIL,
    input wire logic CFG_VALID,
    input wire logic [fault_sup_pkg::CFG_W-1:0] CFG_SENSE,
    input wire logic SOFTSTART_DONE,
    input wire logic [fault_sup_pkg::FLAG_W-1:0] FLAG_CLEAR,
    output fault_sup_pkg::flags_t FLAGS,
    output logic INT_OUT,
    output logic BOOST_EN,
    output logic BOOST_SWITCH_EN,
    output logic LED_EN,
    output logic FET_EN,
    output logic PUMP_EN,
    output logic [fault_sup_pkg::CFG_W-1:0] CHANNEL_CFG,
    output fault_sup_pkg::op_state_t STATE
);
    import fault_sup_pkg::*;

    comp_t comp_s;
    logic [6:0] chk_s;
    logic [6:0] chk_raw;
    logic init_s;
    logic cap_s;
    logic load_s;
    logic cfgv_s;
    logic ss_s;
    logic [CFG_W-1:0] cfg_s;

    // ------------------------------------------------------------
    // Input synchronisation (all inputs except FLAG_CLEAR come from analog or pins)
    // ------------------------------------------------------------
    sync2 #(.W($bits(comp_t))) u_sync_comp (
        .clk(CLK_SYS),
        .rst(RST),
        .d(COMP_IN),
        .q(comp_s)
    );

    assign chk_raw = {INIT_DONE, CAP_FAULT, LOAD_CHECK_FAIL, CFG_VALID,
                      SOFTSTART_DONE, BOOST_CYCLE_LIMIT, 1'b0};

    sync2 #(.W(7)) u_sync_chk (
        .clk(CLK_SYS),
        .rst(RST),
        .d(chk_raw),
        .q(chk_s)
    );

    sync2 #(.W(CFG_W)) u_sync_cfg (
        .clk(CLK_SYS),
        .rst(RST),
        .d(CFG_SENSE),
        .q(cfg_s)
    );

    // Cycle limit (chk_s[1]) is deliberately left unused: it is regulation
    assign init_s = chk_s[6];
    assign cap_s = chk_s[5];
    assign load_s = chk_s[4];
    assign cfgv_s = chk_s[3];
    assign ss_s = chk_s[2];

    // ------------------------------------------------------------
    // State, timers and flags
    // ------------------------------------------------------------
    op_state_t state_r, state_nxt;
    logic [CNT_W-1:0] rtimer_r, rtimer_nxt;
    logic [CNT_W-1:0] utimer_r, utimer_nxt;
    flags_t flags_r, flags_nxt, set_v;
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic checked_r, checked_nxt;
    logic int_r, int_nxt;
    logic boosting;
    logic standby_req;
    logic recover_req;
    logic ocp_expired;

    // Boost is considered running from boost start onward
    assign boosting = (state_r == ST_SOFT) || (state_r == ST_NORMAL);
    assign ocp_expired = (utimer_r == CNT_W'(OCP_CYCLES - 1));

    // Event detection; the trips are levels, flags record them and the capacitor flag also gates PUMP_EN
    always_comb begin
        set_v = '0;
        set_v.input_overvoltage_flag = comp_s.input_ov; // RULE1
        set_v.internal_supply_low_flag = comp_s.supply_low; // RULE3
        set_v.input_overcurrent_flag = comp_s.input_oc; // RULE5
        set_v.charge_pump_low_flag = comp_s.pump_low
            || (init_s && !checked_r && cap_s); // RULE7 RULE8
        set_v.flying_capacitor_fault_flag =
            init_s && !checked_r && cap_s; // RULE8
        set_v.default_load_check_flag =
            init_s && !checked_r && load_s; // RULE9
        set_v.boost_overvoltage_low_flag =
            boosting && comp_s.fb_ov_low; // RULE10 RULE11
        set_v.boost_overvoltage_high_flag = boosting
            && (comp_s.fb_ov_high || comp_s.discharge_ov); // RULE12 RULE13
        set_v.boost_overcurrent_flag =
            boosting && comp_s.fb_under && ocp_expired; // RULE14
        set_v.channel_config_fault_flag =
            init_s && !checked_r && !cfgv_s; // RULE16
        // Standby faults override recovery faults
        standby_req = comp_s.input_ov || comp_s.supply_low;
        // RULE6: cycle-by-cycle limit deliberately absent here
        recover_req = comp_s.input_oc || comp_s.pump_low
            || set_v.flying_capacitor_fault_flag
            || set_v.boost_overvoltage_high_flag
            || set_v.boost_overcurrent_flag;
    end

    // Next-state logic for the operating sequence
    always_comb begin
        state_nxt = state_r;
        rtimer_nxt = '0;
        utimer_nxt = '0;
        checked_nxt = checked_r;
        cfg_nxt = cfg_r;
        if (init_s && !checked_r) begin
            checked_nxt = 1'b1;
            // RULE16 RULE17: latch once, ignore later changes
            cfg_nxt = cfgv_s ? cfg_s : CFG_FALLBACK;
        end
        // RULE15: undervoltage timer runs from boost start
        if (boosting && comp_s.fb_under && !ocp_expired) begin
            utimer_nxt = utimer_r + CNT_W'(1); // RULE14
        end
        unique case (state_r)
            ST_INIT: begin
                if (init_s) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                state_nxt = ST_SOFT;
            end
            ST_SOFT: begin
                if (ss_s) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                state_nxt = ST_NORMAL;
            end
            ST_STANDBY: begin
                // RULE2 RULE4: resume without host action
                if (!standby_req) begin
                    state_nxt = ST_START;
                end
            end
            ST_RECOVER: begin
                // RULE5 RULE7 RULE8 RULE12 RULE14: timed restart
                if (rtimer_r == CNT_W'(RESTART_CYCLES - 1)) begin
                    state_nxt = ST_START;
                end else begin
                    rtimer_nxt = rtimer_r + CNT_W'(1);
                end
            end
            default: begin
                state_nxt = ST_INIT;
            end
        endcase
        // Apart from the capacitor check, faults are not watched before initialisation finishes
        if (state_r != ST_INIT && state_r != ST_STANDBY) begin
            if (standby_req) begin
                state_nxt = ST_STANDBY; // RULE1 RULE3
                rtimer_nxt = '0;
            end else if (recover_req && state_r != ST_RECOVER) begin
                state_nxt = ST_RECOVER;
                rtimer_nxt = '0;
            end
        end else if (state_r == ST_INIT
                     && set_v.flying_capacitor_fault_flag) begin
            // Only the capacitor check may stop start-up in INIT
            state_nxt = ST_RECOVER; // RULE8
        end
    end

    // Sticky flags: a set in the clearing cycle wins over the clear
    always_comb begin
        flags_nxt = (flags_r & ~flags_t'(FLAG_CLEAR)) | set_v; // RULE19
        int_nxt = |flags_nxt;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= ST_INIT;
            rtimer_r <= '0;
            utimer_r <= '0;
            flags_r <= '0;
            cfg_r <= CFG_FALLBACK;
            checked_r <= 1'b0;
            int_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rtimer_r <= rtimer_nxt;
            utimer_r <= utimer_nxt;
            flags_r <= flags_nxt;
            cfg_r <= cfg_nxt;
            checked_r <= checked_nxt;
            int_r <= int_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Enables follow the registered state, so they drop in the same cycle
    // as the fault flag is registered; BOOST_SWITCH_EN drops a cycle earlier on fb_ov_low
    assign FLAGS = flags_r;
    assign INT_OUT = int_r;
    assign BOOST_EN = boosting;
    assign BOOST_SWITCH_EN = boosting && !comp_s.fb_ov_low; // RULE10
    assign LED_EN = (state_r == ST_NORMAL);
    assign FET_EN = (state_r == ST_START) || boosting;
    assign PUMP_EN = (state_r != ST_RECOVER)
        || !flags_r.flying_capacitor_fault_flag; // RULE8
    assign CHANNEL_CFG = cfg_r;
    assign STATE = state_r;
endmodule

// ===== hdl/fault_sup_pkg.sv
package fault_sup_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned RESTART_MS = 100;
    localparam int unsigned OCP_WAIT_MS = 110;
    localparam int unsigned RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
    localparam int unsigned OCP_WAIT_CYC = (CLK_HZ / 1000) * OCP_WAIT_MS;
    localparam int unsigned CNT_W = 21;

    // ------------------------------------------------------------
    // Channel configuration
    // ------------------------------------------------------------
    localparam int unsigned CFG_W = 4;
    // Fallback setting: four channels at 200 mA
    localparam logic [CFG_W-1:0] CFG_FALLBACK = 4'h4;

    // ------------------------------------------------------------
    // Operating state, Gray coded along start, boost, normal path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_START = 3'h1,
        ST_SOFT = 3'h3,
        ST_NORMAL = 3'h2,
        ST_STANDBY = 3'h6,
        ST_RECOVER = 3'h4
    } op_state_t;

    // Digitised comparator results
    typedef struct packed {
        logic input_ov;
        logic supply_low;
        logic input_oc;
        logic pump_low;
        logic fb_ov_low;
        logic fb_ov_high;
        logic discharge_ov;
        logic fb_under;
    } comp_t;

    // Sticky fault flags
    typedef struct packed {
        logic input_overvoltage_flag;
        logic internal_supply_low_flag;
        logic input_overcurrent_flag;
        logic charge_pump_low_flag;
        logic flying_capacitor_fault_flag;
        logic default_load_check_flag;
        logic boost_overvoltage_low_flag;
        logic boost_overvoltage_high_flag;
        logic boost_overcurrent_flag;
        logic channel_config_fault_flag;
    } flags_t;

    localparam int unsigned FLAG_W = $bits(flags_t);

endpackage

// ===== hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // ------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule

// ===== tb/fault_sup_chk.sv
`timescale 1ns/1ps
module fault_sup_chk
    import fault_sup_pkg::*;
#(
    parameter int unsigned RESTART_CYCLES = RESTART_CYC,
    parameter int unsigned OCP_CYCLES = OCP_WAIT_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire fault_sup_pkg::comp_t COMP_IN,
    input wire logic [fault_sup_pkg::FLAG_W-1:0] FLAG_CLEAR,
    input wire fault_sup_pkg::flags_t FLAGS,
    input wire logic INT_OUT,
    input wire logic BOOST_EN,
    input wire logic BOOST_SWITCH_EN,
    input wire logic LED_EN,
    input wire logic FET_EN,
    input wire logic PUMP_EN,
    input wire logic [fault_sup_pkg::CFG_W-1:0] CHANNEL_CFG,
    input wire fault_sup_pkg::op_state_t STATE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [FLAG_W-1:0] fl;
    logic [CNT_W-1:0] rec_cnt_r, rec_cnt_nxt, low_cnt_r, low_cnt_nxt;
    assign fl = FLAGS;
    // Raw counters: input side runs ahead of the synced copy
    always_comb begin
        rec_cnt_nxt = (STATE == ST_RECOVER) ? rec_cnt_r + 1'b1 : '0;
        low_cnt_nxt = COMP_IN.fb_under ? low_cnt_r + 1'b1 : '0;
    end
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rec_cnt_r <= '0;
            low_cnt_r <= '0;
        end else begin
            rec_cnt_r <= rec_cnt_nxt;
            low_cnt_r <= low_cnt_nxt;
        end
    end
    a_int_any_flag: assert property (INT_OUT == (|fl))
        else $error("interrupt disagrees with flags");
    a_outputs_off: assert property (
        (STATE == ST_STANDBY || STATE == ST_RECOVER)
        |-> !(BOOST_EN || LED_EN || FET_EN))
        else $error("power path on while stopped");
    a_flag_sticky: assert property (
        ($past(fl) & ~fl & ~$past(FLAG_CLEAR)) == '0)
        else $error("flag dropped without clear");
    a_cfg_hold: assert property (
        STATE != ST_INIT && $past(STATE) != ST_INIT |-> $stable(CHANNEL_CFG))
        else $error("channel setting moved");
    a_cfg_fallback: assert property (
        FLAGS.channel_config_fault_flag |-> CHANNEL_CFG == CFG_FALLBACK)
        else $error("no fallback setting");
    a_pump_off: assert property (
        !PUMP_EN |-> STATE == ST_RECOVER && FLAGS.flying_capacitor_fault_flag)
        else $error("pump state wrong");
    a_switch_stop: assert property (
        COMP_IN.fb_ov_low [*4] |-> !BOOST_SWITCH_EN)
        else $error("switching during overvoltage");
    a_ovp_standby: assert property (
        COMP_IN.input_ov [*4] ##0 $past(STATE) == ST_NORMAL
        |-> STATE == ST_STANDBY)
        else $error("no standby on overvoltage");
    a_restart_time: assert property (
        STATE == ST_START && $past(STATE) == ST_RECOVER
        |-> rec_cnt_r >= RESTART_CYCLES - 1 && rec_cnt_r <= RESTART_CYCLES + 1)
        else $error("restart delay wrong");
    a_ocp_wait: assert property (
        $rose(FLAGS.boost_overcurrent_flag) |-> low_cnt_r >= OCP_CYCLES)
        else $error("overcurrent flag too early");
endmodule

bind fault_supervisor fault_sup_chk #(
    .RESTART_CYCLES(RESTART_CYCLES),
    .OCP_CYCLES(OCP_CYCLES)
) i_fault_sup_chk (.CLK_SYS, .RST, .COMP_IN, .FLAG_CLEAR, .FLAGS, .INT_OUT,
    .BOOST_EN, .BOOST_SWITCH_EN, .LED_EN, .FET_EN, .PUMP_EN, .CHANNEL_CFG,
    .STATE);

// ===== tb/host_model.sv
`timescale 1ns/1ps
module host_model
    import fault_sup_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic int_out,
    input wire fault_sup_pkg::flags_t flags,
    input wire logic clr_go,
    output logic [fault_sup_pkg::FLAG_W-1:0] flag_clear,
    output fault_sup_pkg::flags_t seen
);
    // Host reads on interrupt, then clears only what it has read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_clear <= '0;
            seen <= '0;
        end else begin
            flag_clear <= clr_go ? seen : '0;
            if (int_out) begin
                seen <= flags;
            end
        end
    end
endmodule

// ===== tb/test_fault_supervisor.sv
`timescale 1ns/1ps
module test_fault_supervisor;
    import fault_sup_pkg::*;
    logic CLK_SYS, RST, BOOST_CYCLE_LIMIT, INIT_DONE, CAP_FAULT, clr_go;
    logic LOAD_CHECK_FAIL, CFG_VALID, SOFTSTART_DONE, INT_OUT, BOOST_EN;
    logic BOOST_SWITCH_EN, LED_EN, FET_EN, PUMP_EN;
    logic [CFG_W-1:0] CFG_SENSE, CHANNEL_CFG;
    logic [FLAG_W-1:0] FLAG_CLEAR;
    comp_t COMP_IN;
    flags_t FLAGS, seen;
    op_state_t STATE;
    int bad_count, tests_run, cycles;
    // Short counts keep the run small: 20 restart, 30 undervoltage
    fault_supervisor #(.RESTART_CYCLES(20), .OCP_CYCLES(30))
    i_fault_supervisor (.CLK_SYS, .RST, .COMP_IN, .BOOST_CYCLE_LIMIT,
        .INIT_DONE, .CAP_FAULT, .LOAD_CHECK_FAIL, .CFG_VALID, .CFG_SENSE,
        .SOFTSTART_DONE, .FLAG_CLEAR, .FLAGS, .INT_OUT, .BOOST_EN,
        .BOOST_SWITCH_EN, .LED_EN, .FET_EN, .PUMP_EN, .CHANNEL_CFG, .STATE);
    host_model i_host_model (.clk(CLK_SYS), .rst(RST), .int_out(INT_OUT),
        .flags(FLAGS), .clr_go(clr_go), .flag_clear(FLAG_CLEAR), .seen(seen));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Look at settled values mid-cycle, then return on a rising edge
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        @(negedge CLK_SYS);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
        @(posedge CLK_SYS);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bounded wait; the caller judges the state reached
    task automatic wait_st(input op_state_t s);
        for (int n = 0; n < 300 && STATE !== s; n++) begin
            @(posedge CLK_SYS);
        end
    endtask
    task automatic clear();
        clr_go <= 1'b1;
        @(posedge CLK_SYS);
        clr_go <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk({INT_OUT, FLAGS}, 11'h000);
    endtask
    task automatic boot(input logic cap, lf, ok, input logic [3:0] cfg);
        @(posedge CLK_SYS);
        RST <= 1'b1;
        CAP_FAULT <= cap;
        LOAD_CHECK_FAIL <= lf;
        CFG_VALID <= ok;
        CFG_SENSE <= cfg;
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (6) @(posedge CLK_SYS);
    endtask
    // Hold a comparator pattern, judge, release, await restart
    task automatic hit(input logic [7:0] cm, input int hold,
        input logic [9:0] ef, input op_state_t es);
        COMP_IN <= cm;
        repeat (hold) @(posedge CLK_SYS);
        chk({INT_OUT, FLAGS}, {|ef, ef});
        chk(STATE, es);
        COMP_IN <= '0;
        wait_st(ST_NORMAL);
        chk(STATE, ST_NORMAL);
        if (ef != '0) begin
            chk(seen, ef);
        end
        clear();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_init();
        boot(1'b0, 1'b1, 1'b0, 4'hA);
        chk({INT_OUT, FLAGS}, 11'h411);
        chk(CHANNEL_CFG, CFG_FALLBACK);
        CFG_SENSE <= 4'h3;
        CFG_VALID <= 1'b1;
        wait_st(ST_NORMAL);
        chk(CHANNEL_CFG, CFG_FALLBACK);
        chk(STATE, ST_NORMAL);
        clear();
    endtask
    task automatic t_supply();
        hit(8'h80, 4, 10'h200, ST_STANDBY);
        hit(8'h40, 4, 10'h100, ST_STANDBY);
    endtask
    task automatic t_recover();
        hit(8'h20, 4, 10'h080, ST_RECOVER);
        hit(8'h10, 4, 10'h040, ST_RECOVER);
        hit(8'h04, 4, 10'h004, ST_RECOVER);
        hit(8'h02, 4, 10'h004, ST_RECOVER);
    endtask
    task automatic t_ov_low();
        COMP_IN <= 8'h08;
        repeat (4) @(posedge CLK_SYS);
        chk({BOOST_SWITCH_EN, BOOST_EN}, 2'b01);
        hit(8'h08, 1, 10'h008, ST_NORMAL);
        hit(8'h08, 4, 10'h008, ST_NORMAL);
    endtask
    task automatic t_gated();
        COMP_IN <= 8'h80;
        repeat (4) @(posedge CLK_SYS);
        hit(8'h8C, 4, 10'h200, ST_STANDBY);
    endtask
    task automatic t_ocp();
        hit(8'h01, 10, 10'h000, ST_NORMAL);
        hit(8'h01, 40, 10'h002, ST_RECOVER);
    endtask
    task automatic t_limit();
        BOOST_CYCLE_LIMIT <= 1'b1;
        repeat (10) @(posedge CLK_SYS);
        chk({INT_OUT, FLAGS}, 11'h000);
        chk(STATE, ST_NORMAL);
        BOOST_CYCLE_LIMIT <= 1'b0;
    endtask
    task automatic t_cap();
        boot(1'b1, 1'b0, 1'b1, 4'h2);
        chk({INT_OUT, FLAGS}, 11'h460);
        chk({PUMP_EN, STATE}, {1'b0, ST_RECOVER});
        chk(CHANNEL_CFG, 4'h2);
        wait_st(ST_NORMAL);
        chk({PUMP_EN, STATE}, {1'b1, ST_NORMAL});
        clear();
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    // Hang guard: the whole sequence needs well under 5000 cycles
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        RST = 1'b1;
        {BOOST_CYCLE_LIMIT, CAP_FAULT, LOAD_CHECK_FAIL} = '0;
        {CFG_VALID, clr_go, COMP_IN, CFG_SENSE} = '0;
        INIT_DONE = 1'b1;
        SOFTSTART_DONE = 1'b1;
        t_init();
        t_supply();
        t_recover();
        t_ov_low();
        t_gated();
        t_ocp();
        t_limit();
        t_cap();
        wrap_up();
    end
endmodule
